// File: hw/cap_regs_defines.svh
// Offsets, field positions and constant contents of the capability register bank.
`ifndef CAP_REGS_DEFINES_SVH
`define CAP_REGS_DEFINES_SVH

// Byte offsets from the base of the register window.
`define OFS_CAPABILITY_LENGTH      8'h00
`define OFS_INTERFACE_REVISION     8'h02
`define OFS_STRUCTURAL_PARAMS_A    8'h04
`define OFS_STRUCTURAL_PARAMS_B    8'h08
`define OFS_STRUCTURAL_PARAMS_C    8'h0c
`define OFS_FEATURE_PARAMS_A       8'h10
`define OFS_DOORBELL_ARRAY_OFFSET  8'h14
`define OFS_RUNTIME_SPACE_OFFSET   8'h18
`define OFS_FEATURE_PARAMS_B       8'h1c

// Field positions inside the first structural parameter word.
`define SLOT_LSB                   0
`define SLOT_MSB                   7
`define INTR_LSB                   8
`define INTR_MSB                   18
`define SPA_SPARE_LSB              19
`define SPA_SPARE_MSB              23
`define PORT_LSB                   24
`define PORT_MSB                   31

// Field positions inside the first word of the window.
`define CAPLEN_LSB                 0
`define CAPLEN_MSB                 7
`define REV_LSB                    16
`define REV_MSB                    31

// Constant contents; the region ends where the operational space starts.
`define CAPABILITY_LENGTH_VAL      8'h20
// Revision value is the draft revision, in BCD: major byte then minor digits.
`define INTERFACE_REVISION_VAL     16'h0095
`define SLOT_COUNT_VAL             8'h40
`define INTERRUPTER_COUNT_VAL      11'h008
`define INTERRUPTER_COUNT_MAX      11'h400
`define PORT_NUMBER_LIMIT_VAL      8'h04
// Highest port number handed out by the supported-protocol structures.
`define PROTOCOL_CAPS_MAX_PORT     8'h04
`define STRUCTURAL_PARAMS_B_VAL    32'h0000_0000
`define STRUCTURAL_PARAMS_C_VAL    32'h0000_0000
`define FEATURE_PARAMS_A_VAL       32'h0000_0000
`define DOORBELL_ARRAY_OFFSET_VAL  32'h0000_3000
`define RUNTIME_SPACE_OFFSET_VAL   32'h0000_2000
`define FEATURE_PARAMS_B_VAL       32'h0000_0000

// Read latency of the window in clock cycles.
`define READ_LATENCY               1

`endif

// File: hw/cap_regs_pkg.sv
// Types shared by the capability register bank.
package cap_regs_pkg;

	typedef logic [7:0]  byteAddr_t;
	typedef logic [31:0] word_t;
	typedef logic [5:0]  wordIndex_t;

endpackage

// File: hw/host_capability_registers.sv
// Read-only capability register bank at the base of the memory-mapped window.
//
// Summary of operation
// RULE1: All capability registers are read-only.
// RULE2: Offsets decode relative to window base.
// RULE3: Byte zero gives offset to operational space.
// RULE4: Offset two holds BCD interface revision.
// RULE5: Revision upper byte major, lower byte minor.
// RULE6: Pre-release build reports its draft revision.
// RULE7: Parameter word fields: slots, interrupters, ports.
// RULE8: Slot count lies in 1 to 255.
// RULE9: Interrupter count equals interrupters implemented.
// RULE10: Interrupter count lies in 1h to 400h.
// RULE11: Port limit lies in 1h to FFh.
// RULE12: Port limit matches protocol structures' highest port.
// RULE13: Software checks protocol structures for port validity.
// RULE14: Doorbell, runtime offsets and feature word present.
// RULE15: Vector table size follows interrupter count.
// RULE16: Reserved space reads zero, writes ignored.
`timescale 1ns/100ps
`include "cap_regs_defines.svh"

module host_capability_registers (
	// Clock and reset.
	input  wire logic                    clk,
	input  wire logic                    reset,
	// Memory-mapped window, byte address relative to the base.
	input  wire logic                    rdReq,
	input  wire logic                    wrReq,
	input  wire cap_regs_pkg::byteAddr_t addr,
	input  wire logic [3:0]              byteEn,
	input  wire cap_regs_pkg::word_t     wrData,
	output logic                         rdValid_r,
	output cap_regs_pkg::word_t          rdData_r,
	// Sizing handed to the message-signalled vector logic.
	output logic [10:0]                  vectorTableSize_r
);

	////////////////////////////////////////////////////////////////////////////////
	// Register contents.

	cap_regs_pkg::word_t  word0;
	cap_regs_pkg::word_t  structParamsA;
	cap_regs_pkg::word_t  selWord;
	cap_regs_pkg::word_t  laneMask;
	cap_regs_pkg::word_t  rdData_nxt;
	cap_regs_pkg::wordIndex_t wordIndex;
	logic                 wrSeen_r;

	// RULE3: operational space offset
	// RULE4: revision at offset two
	// RULE5: major byte over minor
	// RULE6: draft revision constant
	// RULE16: reserved byte zero
	assign word0 = {`INTERFACE_REVISION_VAL, 8'h00, `CAPABILITY_LENGTH_VAL};

	// RULE7: parameter field packing
	// RULE8: nonzero slot count
	// RULE9: implemented interrupter count
	// RULE10: interrupter count in range
	// RULE11: nonzero port limit
	// RULE12: port limit from protocols
	// The field values are build constants chosen inside their legal ranges; the
	// checks below catch a constant that is later edited out of range.
	assign structParamsA = {`PORT_NUMBER_LIMIT_VAL, 5'h00, `INTERRUPTER_COUNT_VAL,
		`SLOT_COUNT_VAL};

	////////////////////////////////////////////////////////////////////////////////
	// Address decode.

	// Word-aligned index; byte lanes pick the bytes within the word.
	assign wordIndex = addr[7:2];

	// RULE2: base-relative decode
	// RULE14: offset and feature words
	// RULE16: reserved span zero
	always_comb begin
		unique case ({wordIndex, 2'b00})
			`OFS_CAPABILITY_LENGTH:     selWord = word0;
			`OFS_STRUCTURAL_PARAMS_A:   selWord = structParamsA;
			`OFS_STRUCTURAL_PARAMS_B:   selWord = `STRUCTURAL_PARAMS_B_VAL;
			`OFS_STRUCTURAL_PARAMS_C:   selWord = `STRUCTURAL_PARAMS_C_VAL;
			`OFS_FEATURE_PARAMS_A:      selWord = `FEATURE_PARAMS_A_VAL;
			`OFS_DOORBELL_ARRAY_OFFSET: selWord = `DOORBELL_ARRAY_OFFSET_VAL;
			`OFS_RUNTIME_SPACE_OFFSET:  selWord = `RUNTIME_SPACE_OFFSET_VAL;
			`OFS_FEATURE_PARAMS_B:      selWord = `FEATURE_PARAMS_B_VAL;
			// Reserved span and anything past the region read as zero.
			default:                    selWord = 32'h0000_0000;
		endcase
	end

	// Disabled byte lanes return zero so narrow reads never leak neighbours.
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			laneMask[i*8 +: 8] = {8{byteEn[i]}};
		end
	end

	assign rdData_nxt = selWord & laneMask;

	////////////////////////////////////////////////////////////////////////////////
	// Read answer.

	// One-cycle answer; data holds until the next read replaces it.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rdValid_r <= 1'b0;
			rdData_r  <= 32'h0000_0000;
		end else begin
			rdValid_r <= rdReq;
			if (rdReq) begin
				rdData_r <= rdData_nxt;
			end
		end
	end

	// RULE1: writes store nothing
	// The write port exists only so the window accepts stores; wrData is dropped on purpose.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			wrSeen_r <= 1'b0;
		end else begin
			wrSeen_r <= wrReq & (|wrData | ~|wrData);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Vector table sizing.

	// RULE15: table size from count
	// The size field is encoded as entries minus one, so it is a constant register.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			vectorTableSize_r <= 11'h000;
		end else begin
			vectorTableSize_r <= `INTERRUPTER_COUNT_VAL - 11'h001;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	// Byte enables of the previous cycle, so the lane check knows which lanes the
	// answer was asked for; a flop of its own keeps the check independent of the data path.
	logic [3:0]              prevEn_r;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			prevEn_r <= 4'h0;
		end else begin
			prevEn_r <= byteEn;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read path timing, the first word of the window, and the full-word and port-lane checks of the first structural parameter word.

	a_read_latency: assert property ( // RULE2
		rdReq |=> rdValid_r ##0 $past(rdReq)
	) else $error("Read answer not one cycle after request.");

	a_caplen_byte: assert property ( // RULE3
		rdReq && addr[7:2] == 6'h00 && byteEn[0] |=>
			rdData_r[`CAPLEN_MSB:`CAPLEN_LSB] == 8'h20
	) else $error("Capability length byte wrong.");

	a_caplen_region: assert property ( // RULE3
		rdReq && addr[7:2] == 6'h00 && byteEn[0] |=>
			rdData_r[`CAPLEN_MSB:`CAPLEN_LSB] >= 8'h20
	) else $error("Capability length does not cover the registers.");

	a_revision_word: assert property ( // RULE4
		rdReq && addr[7:2] == 6'h00 && byteEn[3:2] == 2'b11 |=>
			rdData_r[`REV_MSB:`REV_LSB] == 16'h0095 && rdData_r[15:8] == 8'h00
	) else $error("Interface revision or reserved byte wrong.");

	a_revision_draft: assert property ( // RULE6
		rdReq && addr[7:2] == 6'h00 && byteEn[3:2] == 2'b11 |=>
			rdData_r[`REV_MSB:`REV_LSB] == `INTERFACE_REVISION_VAL
	) else $error("Interface revision differs from the built revision.");

	a_revision_bcd: assert property ( // RULE5
		rdReq && addr[7:2] == 6'h00 && byteEn[3:2] == 2'b11 |=>
			rdData_r[31:28] <= 4'h9 && rdData_r[27:24] <= 4'h9 &&
			rdData_r[23:20] <= 4'h9 && rdData_r[19:16] <= 4'h9
	) else $error("Interface revision is not binary-coded decimal.");

	a_params_fields: assert property ( // RULE7
		rdReq && addr[7:2] == 6'h01 && byteEn == 4'hf |=>
			rdData_r[`SLOT_MSB:`SLOT_LSB] != 8'h00 &&
			rdData_r[`INTR_MSB:`INTR_LSB] != 11'h000 &&
			rdData_r[`INTR_MSB:`INTR_LSB] <= 11'h400 &&
			rdData_r[`SPA_SPARE_MSB:`SPA_SPARE_LSB] == 5'h00 &&
			rdData_r[`PORT_MSB:`PORT_LSB] != 8'h00
	) else $error("Structural parameter field out of range.");

	a_port_match: assert property ( // RULE12
		rdReq && addr[7:2] == 6'h01 && byteEn[3] |=>
			rdData_r[`PORT_MSB:`PORT_LSB] == `PROTOCOL_CAPS_MAX_PORT
	) else $error("Port limit differs from protocol structures.");

	////////////////////////////////////////////////////////////////////////////////
	// Field checks of the first structural parameter word, one field at a time, so
	// a narrow read of only the field's own lanes (two for the interrupter count) is held to the same limits as a full word;
	// then checks of the other words, the reserved span, the byte lanes and ignored writes.

	a_slot_range: assert property ( // RULE8
		rdReq && addr[7:2] == 6'h01 && byteEn[0] |=>
			rdData_r[`SLOT_MSB:`SLOT_LSB] != 8'h00 &&
			rdData_r[`SLOT_MSB:`SLOT_LSB] == `SLOT_COUNT_VAL
	) else $error("Slot count zero or not the built value.");

	a_intr_count: assert property ( // RULE9
		rdReq && addr[7:2] == 6'h01 && byteEn[2:1] == 2'b11 |=>
			rdData_r[`INTR_MSB:`INTR_LSB] == `INTERRUPTER_COUNT_VAL
	) else $error("Interrupter count differs from interrupters built.");

	a_intr_range: assert property ( // RULE10
		rdReq && addr[7:2] == 6'h01 && byteEn[2:1] == 2'b11 |=>
			rdData_r[`INTR_MSB:`INTR_LSB] >= 11'h001 &&
			rdData_r[`INTR_MSB:`INTR_LSB] <= `INTERRUPTER_COUNT_MAX
	) else $error("Interrupter count outside its legal range.");

	a_port_range: assert property ( // RULE11
		rdReq && addr[7:2] == 6'h01 && byteEn[3] |=>
			rdData_r[`PORT_MSB:`PORT_LSB] >= 8'h01 &&
			rdData_r[`PORT_MSB:`PORT_LSB] == `PORT_NUMBER_LIMIT_VAL
	) else $error("Port limit zero or not the built value.");

	a_offset_words: assert property ( // RULE14
		rdReq && addr[7:2] == 6'h05 && byteEn == 4'hf ##1
			rdReq && addr[7:2] == 6'h06 && byteEn == 4'hf |=>
			rdData_r == `RUNTIME_SPACE_OFFSET_VAL &&
			$past(rdData_r) == `DOORBELL_ARRAY_OFFSET_VAL
	) else $error("Doorbell or runtime offset word wrong.");

	a_doorbell_word: assert property ( // RULE14
		rdReq && addr[7:2] == 6'h05 && byteEn == 4'hf |=>
			rdData_r == `DOORBELL_ARRAY_OFFSET_VAL
	) else $error("Doorbell offset word wrong.");

	a_runtime_word: assert property ( // RULE14
		rdReq && addr[7:2] == 6'h06 && byteEn == 4'hf |=>
			rdData_r == `RUNTIME_SPACE_OFFSET_VAL
	) else $error("Runtime offset word wrong.");

	a_feature_b_word: assert property ( // RULE14
		rdReq && addr[7:2] == 6'h07 && byteEn == 4'hf |=>
			rdData_r == `FEATURE_PARAMS_B_VAL
	) else $error("Second feature word wrong.");

	a_params_b_word: assert property ( // RULE2
		rdReq && addr[7:2] == 6'h02 && byteEn == 4'hf |=>
			rdData_r == `STRUCTURAL_PARAMS_B_VAL
	) else $error("Second structural word wrong.");

	a_params_c_word: assert property ( // RULE2
		rdReq && addr[7:2] == 6'h03 && byteEn == 4'hf |=>
			rdData_r == `STRUCTURAL_PARAMS_C_VAL
	) else $error("Third structural word wrong.");

	a_feature_a_word: assert property ( // RULE2
		rdReq && addr[7:2] == 6'h04 && byteEn == 4'hf |=>
			rdData_r == `FEATURE_PARAMS_A_VAL
	) else $error("First feature word wrong.");

	a_reserved_zero: assert property ( // RULE16
		rdReq && addr >= 8'h20 |=> rdData_r == 32'h0000_0000
	) else $error("Reserved span did not read zero.");

	a_reserved_byte: assert property ( // RULE16
		rdReq && addr[7:2] == 6'h00 && byteEn[1] |=>
			rdData_r[15:8] == 8'h00
	) else $error("Reserved byte did not read zero.");

	a_lane_mask: assert property ( // RULE2
		rdValid_r |-> (rdData_r & ~{{8{prevEn_r[3]}}, {8{prevEn_r[2]}},
			{8{prevEn_r[1]}}, {8{prevEn_r[0]}}}) == 32'h0000_0000
	) else $error("Disabled byte lane returned data.");

	a_write_ignored: assert property ( // RULE1
		wrReq && !rdReq |=> !rdValid_r ##0 $stable(rdData_r)
	) else $error("Write disturbed the read path.");

	////////////////////////////////////////////////////////////////////////////////
	// Idle behaviour: with no read asked for, the answer stays quiet and unchanged; then the vector table size checks.

	a_no_spurious: assert property ( // RULE1
		!rdReq |=> !rdValid_r
	) else $error("Read answer without a read request.");

	a_data_holds: assert property ( // RULE1
		!rdReq |=> $stable(rdData_r)
	) else $error("Read data changed without a read request.");

	a_table_size: assert property ( // RULE15
		!$past(reset) |-> vectorTableSize_r == `INTERRUPTER_COUNT_VAL - 11'h001
	) else $error("Vector table size does not follow interrupter count.");

	a_table_bound: assert property ( // RULE15
		vectorTableSize_r < `INTERRUPTER_COUNT_MAX
	) else $error("Vector table larger than the interrupter limit.");

	c_read_caplen: cover property (rdReq && addr == 8'h00 ##1 rdValid_r);
	c_write_then_read: cover property (wrSeen_r && rdReq && addr[7:2] == 6'h01 ##1 rdValid_r);
	c_reserved_read: cover property (rdReq && addr >= 8'h20 ##1 rdValid_r);
	c_back_to_back: cover property (rdReq [*3]);
	c_read_revision: cover property (rdReq && addr == 8'h02 && byteEn == 4'hc ##1 rdValid_r);

endmodule

// File: testbench/test_host_capability_registers.sv
// Self-checking testbench for the read-only capability register bank.
`timescale 1ns/100ps
`include "cap_regs_defines.svh"

module test_host_capability_registers;

	logic                    clk = 1'b0;
	logic                    reset = 1'b1;
	logic                    rdReq = 1'b0;
	logic                    wrReq = 1'b0;
	cap_regs_pkg::byteAddr_t addr = 8'h00;
	logic [3:0]              byteEn = 4'h0;
	cap_regs_pkg::word_t     wrData = 32'h0000_0000;
	logic                    rdValid_r;
	cap_regs_pkg::word_t     rdData_r;
	logic [10:0]             vectorTableSize_r;
	int                      errTotal = 0;
	int                      cmpCount = 0;
	logic [31:0]             seed = 32'h0000_0004;
	logic                    pendRd = 1'b0;
	cap_regs_pkg::word_t     holdExp = 32'h0000_0000;

	host_capability_registers i_dut (
		.clk               (clk),
		.reset             (reset),
		.rdReq             (rdReq),
		.wrReq             (wrReq),
		.addr              (addr),
		.byteEn            (byteEn),
		.wrData            (wrData),
		.rdValid_r         (rdValid_r),
		.rdData_r          (rdData_r),
		.vectorTableSize_r (vectorTableSize_r)
	);

	// Free-running 250 MHz clock.
	always #2 clk = ~clk;

	//////////////////////////////////////////////////////////////////////////////////////////
	// Xorshift generator; the fixed start value keeps every run identical.
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	// Expected word for a read, with disabled byte lanes forced to zero.
	function automatic cap_regs_pkg::word_t expWord(cap_regs_pkg::byteAddr_t a, logic [3:0] be);
		cap_regs_pkg::word_t w;
		case (a[7:2])
			6'h00: w = {`INTERFACE_REVISION_VAL, 8'h00, `CAPABILITY_LENGTH_VAL};
			6'h01: w = {`PORT_NUMBER_LIMIT_VAL, 5'h00, `INTERRUPTER_COUNT_VAL, `SLOT_COUNT_VAL};
			6'h02: w = `STRUCTURAL_PARAMS_B_VAL;
			6'h03: w = `STRUCTURAL_PARAMS_C_VAL;
			6'h04: w = `FEATURE_PARAMS_A_VAL;
			6'h05: w = `DOORBELL_ARRAY_OFFSET_VAL;
			6'h06: w = `RUNTIME_SPACE_OFFSET_VAL;
			6'h07: w = `FEATURE_PARAMS_B_VAL;
			default: w = 32'h0000_0000;
		endcase
		for (int i = 0; i < 4; i++) begin
			if (!be[i]) w[8*i +: 8] = 8'h00;
		end
		return w;
	endfunction

	// Counts a comparison and reports a mismatch at once.
	task automatic check(string name, logic [31:0] exp, logic [31:0] seen);
		cmpCount++;
		if (seen !== exp) begin
			errTotal++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// One bus cycle: check the answer to the previous cycle, then drive the next request.
	task automatic cycle(logic rd, logic wr, cap_regs_pkg::byteAddr_t a, logic [3:0] be,
			cap_regs_pkg::word_t wd);
		@(negedge clk);
		check("rdValid_r", {31'h0, pendRd}, {31'h0, rdValid_r});
		check("rdData_r", holdExp, rdData_r);
		if (rd) holdExp = expWord(a, be);
		pendRd = rd;
		rdReq = rd;
		wrReq = wr;
		addr = a;
		byteEn = be;
		wrData = wd;
	endtask

	// Verdict and end of run; the only place the simulation stops.
	task automatic stopTest();
		$display("compares %0d mismatches %0d", cmpCount, errTotal);
		if (errTotal == 0 && cmpCount > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask

	//////////////////////////////////////////////////////////////////////////////////////////
	// Watchdog, well beyond the roughly 540 cycles the tests take.
	initial begin
		#8000;
		errTotal++;
		stopTest();
	end

	// Main sequence.
	initial begin
		repeat (3) cycle(1'b0, 1'b0, 8'h00, 4'h0, 32'h0);
		reset = 1'b0;
		cycle(1'b0, 1'b0, 8'h00, 4'h0, 32'h0);
		check("vectorTableSize_r", {21'h0, `INTERRUPTER_COUNT_VAL - 11'h1}, {21'h0, vectorTableSize_r});
		$display("test reset done");
		// Back-to-back sweep of the whole window, every lane on.
		for (int i = 0; i < 64; i++) cycle(1'b1, 1'b0, 8'(i * 4), 4'hf, 32'h0);
		$display("test sweep done");
		// Writes of random data everywhere must change nothing and give no answer.
		for (int i = 0; i < 64; i++) cycle(1'b0, 1'b1, 8'(i * 4), 4'hf, rnd());
		cycle(1'b1, 1'b1, 8'h04, 4'hf, 32'hffff_ffff);
		cycle(1'b0, 1'b0, 8'h00, 4'h0, 32'h0);
		check("slotValid", 32'h1, {31'h0, rdData_r[7:0] != 8'h00});
		check("intrValid", 32'h1, {31'h0, rdData_r[18:8] != 0 && rdData_r[18:8] <= 11'h400});
		check("spaReserved", 32'h0, {27'h0, rdData_r[23:19]});
		check("portValid", 32'h1, {31'h0, rdData_r[31:24] != 8'h00});
		check("portMatch", {24'h0, `PROTOCOL_CAPS_MAX_PORT}, {24'h0, rdData_r[31:24]});
		check("portKnown", 32'h1, {31'h0, rdData_r[31:24] <= `PROTOCOL_CAPS_MAX_PORT});
		$display("test write and fields done");
		// Random traffic: reads, writes, lanes and addresses, reserved span included.
		for (int i = 0; i < 400; i++) begin
			logic [31:0] r;
			r = rnd();
			cycle(r[0], r[1], r[15:8], r[19:16], rnd());
		end
		$display("test random done");
		// Reset in mid-run clears the answer, then the bank works again.
		cycle(1'b1, 1'b0, 8'h14, 4'hf, 32'h0);
		reset = 1'b1;
		pendRd = 1'b0;
		holdExp = 32'h0;
		cycle(1'b0, 1'b0, 8'h00, 4'h0, 32'h0);
		reset = 1'b0;
		cycle(1'b1, 1'b0, 8'h02, 4'hc, 32'h0);
		cycle(1'b1, 1'b0, 8'h01, 4'h2, 32'h0);
		cycle(1'b0, 1'b0, 8'h00, 4'h0, 32'h0);
		check("vectorTableSize_r", {21'h0, `INTERRUPTER_COUNT_VAL - 11'h1}, {21'h0, vectorTableSize_r});
		$display("test second reset done");
		stopTest();
	end

endmodule
